/* File: hw/idle_domain_control_status.sv */
// Idle domain controller with AXI4-Lite register access.
// Assumes the idle instruction and wake request come from core logic on
// ref_clk as one-cycle pulses; gate outputs go to local clock gaters.
`include "idle_domain_params.svh"
`timescale 1ns/1ps
`default_nettype none

module idle_domain_control_status (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Core side
	input  wire logic        idleExec,
	input  wire logic        wakeReq,
	output logic [8:0]       domainGate,
	output logic [15:0]      periphGate,
	output logic             irq
);

	//------------------------------------------------------------
	// Registers
	//------------------------------------------------------------

	idle_domain_pkg::idle_cfg_t  cfg_reg;
	logic [15:0]                 mask_reg;
	logic [8:0]                  gate_reg;
	logic [8:0]                  gate_next;
	logic [15:0]                 periph_reg;
	logic [15:0]                 periph_next;
	logic                        groupIdle_reg;
	logic                        groupIdle_next;
	idle_domain_pkg::ctrl_state_t state_reg;
	logic [2:0]                  evtStat_reg;
	logic [2:0]                  evtEn_reg;
	logic [2:0]                  evtSet;
	logic [15:0]                 statusWord;
	logic [15:0]                 cfgWord;
	logic                        clkReqMissing;

	// AXI write side holds
	idle_domain_pkg::wr_hold_t   aw_reg;
	idle_domain_pkg::wr_hold_t   w_reg;
	logic [3:0]                  wstrb_reg;
	logic                        doWrite;
	logic [3:0]                  wrIdx;
	logic [3:0]                  rdIdx;
	logic [15:0]                 wrLanes;
	logic                        wrEvtClr;
	logic [2:0]                  clrBits;

	assign cfgWord = cfg_reg;

	//------------------------------------------------------------
	// Idle entry decision
	//------------------------------------------------------------

	// Every domain the clock generator depends on must be requested
	assign clkReqMissing = cfg_reg.clock_gen_idle_sel &&
		((cfgWord & `CLK_REQ_MASK) != `CLK_REQ_MASK);

	// Next gated state for the domains driven by config selects
	always_comb begin
		gate_next      = gate_reg;
		periph_next    = periph_reg;
		groupIdle_next = groupIdle_reg;
		if (wakeReq) begin
			// Wake restores every domain; a late idle loses to it
			gate_next      = 9'h000;
			periph_next    = 16'h0000;
			groupIdle_next = 1'b0;
		end else if (idleExec && !clkReqMissing) begin
			gate_next[0] = cfg_reg.core_idle_sel;
			gate_next[1] = cfg_reg.master_periph_idle_sel;
			gate_next[2] = cfg_reg.instr_cache_idle_sel;
			gate_next[4] = cfg_reg.clock_gen_idle_sel;
			gate_next[5] = cfg_reg.ext_mem_if_sel;
			gate_next[6] = cfg_reg.io_port_sel;
			gate_next[7] = cfg_reg.master_port_sel;
			gate_next[8] = cfg_reg.fetch_port_sel;
			if (cfg_reg.periph_group_idle_sel) begin
				// Masked ones idle; unmasked ones wake
				periph_next    = mask_reg;
				groupIdle_next = 1'b1;
			end else begin
				// Group wake ignores the mask entirely
				periph_next    = 16'h0000;
				groupIdle_next = 1'b0;
			end
			gate_next[3] = groupIdle_next;
		end
	end

	// Gated state, held until the next idle or wake
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			gate_reg      <= 9'h000;
			periph_reg    <= 16'h0000;
			groupIdle_reg <= 1'b0;
		end else begin
			gate_reg      <= gate_next;
			periph_reg    <= periph_next;
			groupIdle_reg <= groupIdle_next;
		end
	end

	// Overall state follows whether any domain is gated
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= idle_domain_pkg::ST_RUN;
		end else begin
			case (state_reg)
				idle_domain_pkg::ST_RUN: begin
					if (gate_next != 9'h000 || periph_next != 16'h0000)
						state_reg <= idle_domain_pkg::ST_IDLED;
				end
				idle_domain_pkg::ST_IDLED: begin
					if (gate_next == 9'h000 && periph_next == 16'h0000)
						state_reg <= idle_domain_pkg::ST_RUN;
				end
				default: begin
					state_reg <= idle_domain_pkg::ST_RUN;
				end
			endcase
		end
	end

	assign domainGate = gate_reg;
	assign periphGate = periph_reg;

	//------------------------------------------------------------
	// Status word
	//------------------------------------------------------------

	// Built from gated state, never from the config selects
	always_comb begin
		statusWord      = `STATUS_RESET;
		statusWord[0]   = gate_reg[0];
		statusWord[1]   = gate_reg[1];
		statusWord[2]   = gate_reg[2];
		statusWord[3]   = groupIdle_reg;
		statusWord[4]   = gate_reg[4];
		statusWord[5]   = gate_reg[5];
		statusWord[6]   = gate_reg[6];
		statusWord[7]   = gate_reg[7];
		statusWord[8]   = gate_reg[8];
	end

	//------------------------------------------------------------
	// Interrupt events
	//------------------------------------------------------------

	always_comb begin
		evtSet = 3'h0;
		evtSet[`EVT_BUS_ERR] = idleExec && clkReqMissing && !wakeReq;
		evtSet[`EVT_ENTERED] = idleExec && !clkReqMissing && !wakeReq;
		evtSet[`EVT_WOKE]    = wakeReq && (state_reg ==
			idle_domain_pkg::ST_IDLED);
	end

	// Sticky status; a set in the clear cycle wins
	always_ff @(posedge ref_clk) begin
		if (rst)
			evtStat_reg <= 3'h0;
		else
			evtStat_reg <= (evtStat_reg & ~clrBits) | evtSet;
	end

	assign irq = |(evtStat_reg & evtEn_reg);

	//------------------------------------------------------------
	// AXI4-Lite write channel
	//------------------------------------------------------------

	// Address and data may arrive in either order; each is held once
	assign s_axi_awready = !aw_reg.valid && !s_axi_bvalid;
	assign s_axi_wready  = !w_reg.valid && !s_axi_bvalid;
	assign doWrite       = aw_reg.valid && w_reg.valid && !s_axi_bvalid;
	assign wrIdx         = aw_reg.data[5:2];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			aw_reg <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_reg.valid <= 1'b1;
			aw_reg.data  <= {24'h000000, s_axi_awaddr};
		end else if (doWrite) begin
			aw_reg.valid <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			w_reg     <= '0;
			wstrb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_reg.valid <= 1'b1;
			w_reg.data  <= s_axi_wdata;
			wstrb_reg   <= s_axi_wstrb;
		end else if (doWrite) begin
			w_reg.valid <= 1'b0;
		end
	end

	// Byte lanes over the low half-word only
	assign wrLanes = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	// A misaligned write answers DECERR and must not touch anything
	assign wrEvtClr = doWrite && (aw_reg.data[7:6] == 2'h0) &&
		(aw_reg.data[1:0] == 2'h0) && (wrIdx == `IDX_EVT_CLR);
	assign clrBits = wrEvtClr ? (w_reg.data[2:0] & wrLanes[2:0]) : 3'h0;

	// Register writes; status writes fall through untouched
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg_reg   <= `CONFIG_RESET;
			mask_reg  <= `MASK_RESET;
			evtEn_reg <= 3'h0;
		end else if (doWrite && aw_reg.data[7:6] == 2'h0 &&
			aw_reg.data[1:0] == 2'h0) begin
			if (wrIdx == `IDX_CONFIG) begin
				cfg_reg <= (cfgWord & ~(wrLanes & `CONFIG_WMASK)) |
					(w_reg.data[15:0] & wrLanes & `CONFIG_WMASK);
			end else if (wrIdx == `IDX_MASK) begin
				mask_reg <= (mask_reg & ~(wrLanes & `MASK_WMASK)) |
					(w_reg.data[15:0] & wrLanes & `MASK_WMASK);
			end else if (wrIdx == `IDX_EVT_EN) begin
				evtEn_reg <= (evtEn_reg & ~wrLanes[2:0]) |
					(w_reg.data[2:0] & wrLanes[2:0]);
			end
		end
	end

	// Write response; status is accepted but ignored
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			if (aw_reg.data[7:6] != 2'h0 || aw_reg.data[1:0] != 2'h0)
				s_axi_bresp <= `RESP_DECERR;
			else if (wrIdx >= `IDX_CONFIG && wrIdx <= `IDX_EVT_EN)
				s_axi_bresp <= `RESP_OKAY;
			else
				s_axi_bresp <= `RESP_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// AXI4-Lite read channel
	//------------------------------------------------------------

	assign s_axi_arready = !s_axi_rvalid;
	assign rdIdx         = s_axi_araddr[5:2];

	// Read data registered one cycle after the address is taken
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `RESP_OKAY;
			s_axi_rdata  <= 32'h00000000;
			if (s_axi_araddr[7:6] != 2'h0 || s_axi_araddr[1:0] != 2'h0)
				s_axi_rresp <= `RESP_DECERR;
			else if (rdIdx == `IDX_CONFIG)
				s_axi_rdata <= {16'h0000, cfgWord};
			else if (rdIdx == `IDX_STATUS)
				s_axi_rdata <= {16'h0000, statusWord};
			else if (rdIdx == `IDX_MASK)
				s_axi_rdata <= {16'h0000, mask_reg};
			else if (rdIdx == `IDX_EVT_STAT)
				s_axi_rdata <= {29'h00000000, evtStat_reg};
			else if (rdIdx == `IDX_EVT_CLR)
				s_axi_rdata <= 32'h00000000; // Write-only reads zero
			else if (rdIdx == `IDX_EVT_EN)
				s_axi_rdata <= {29'h00000000, evtEn_reg};
			else
				s_axi_rresp <= `RESP_DECERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

`default_nettype wire

/* File: hw/idle_domain_params.svh */
// Constants for the idle domain controller: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the design file.
//
// Overview of operation
// - Peripheral group select 0 at idle keeps or wakes every peripheral.
// - Peripheral group select 1 at idle disables only peripherals masked 1.
// - Config bit 2: 0 keeps instruction cache running, 1 disables it.
// - Config bit 1: 0 keeps DMA and host port active, 1 disables both.
// - Config bit 0: 0 keeps the CPU running, 1 disables it.
// - Read-only 16-bit status at 0x0002; bits 15..9 zero; resets to 0.
// - Status bit 8 is 1 while the fetch port is disabled.
// - Status bit 7 is 1 while the master port is disabled.
// - Status bit 6 is 1 while the I/O space port is disabled.
// - Status bit 5 is 1 while the external memory interface is idled.
// - Status bit 4 is 1 while the clock generator is disabled.
// - Status bit 3 is 1 while the peripheral group is idled.
// - Status bit 2 is 1 while the instruction cache is disabled.
// - Status bit 1 is 1 while DMA and host port are disabled.
// - Status bit 0 is 1 while the CPU is disabled.
// - Clock generator idle with any of config bits 9..5 or 2..0 clear raises bus error.
// - Group select 0 at idle wakes all peripherals, ignoring the mask.
`ifndef IDLE_DOMAIN_PARAMS_SVH
`define IDLE_DOMAIN_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_CONFIG    4'h1
`define IDX_STATUS    4'h2
`define IDX_MASK      4'h3
`define IDX_EVT_STAT  4'h4
`define IDX_EVT_CLR   4'h5
`define IDX_EVT_EN    4'h6

// Configuration bit positions
`define BIT_CORE      0
`define BIT_CACHE     2
`define BIT_PERIPH    3
`define BIT_CLKGEN    4
`define BIT_CLKEN     9
`define NUM_DOMAINS   9

// Writable and reset masks
`define CONFIG_WMASK  16'h03ff
`define MASK_WMASK    16'h3fff
`define CONFIG_RESET  16'h0000
`define MASK_RESET    16'h0000
`define STATUS_RESET  16'h0000
// Domains that must be idled alongside the clock generator
`define CLK_REQ_MASK  16'h03e7

// Interrupt event bits
`define EVT_BUS_ERR   0
`define EVT_ENTERED   1
`define EVT_WOKE      2
`define NUM_EVENTS    3

// Bus answers
`define RESP_OKAY     2'h0
`define RESP_DECERR   2'h3

`endif

/* File: hw/idle_domain_pkg.sv */
// Types shared by the idle domain controller.
// Assumes the constants header sits beside it.
`include "idle_domain_params.svh"

package idle_domain_pkg;

	// Overall controller state
	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_IDLED = 2'b01
	} ctrl_state_t;

	// Idle configuration layout, one select per domain
	typedef struct packed {
		logic [5:0] spare;
		logic       clock_gen_idle_enable;
		logic       fetch_port_sel;
		logic       master_port_sel;
		logic       io_port_sel;
		logic       ext_mem_if_sel;
		logic       clock_gen_idle_sel;
		logic       periph_group_idle_sel;
		logic       instr_cache_idle_sel;
		logic       master_periph_idle_sel;
		logic       core_idle_sel;
	} idle_cfg_t;

	// Latched half of an AXI4-Lite write
	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} wr_hold_t;

endpackage

/* File: verification/idle_domain_properties.sv */
// Port-level assertions for the idle domain controller.
// Assumes one clock and a synchronous active-high reset; bound below.
`timescale 1ns/1ps
`default_nettype none

module idle_domain_properties (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        idleExec,
	input wire logic        wakeReq,
	input wire logic [8:0]  domainGate,
	input wire logic [15:0] periphGate,
	input wire logic        irq
);
	// --------------------------------------------------
	// Gate and register relations
	// --------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Gates move only on an idle or a wake request
	chk_gate_hold: assert property (!idleExec && !wakeReq |=>
		$stable(domainGate) && $stable(periphGate)) else $error("gate moved");
	chk_periph_group: assert property (periphGate != 16'h0 |->
		domainGate[3]) else $error("peripheral gated outside group");
	chk_clkgen_full: assert property (domainGate[4] |->
		&domainGate[8:5] && &domainGate[2:0]) else $error("clock gen alone");
	chk_wake_all: assert property (wakeReq |=>
		domainGate == 9'h0 && periphGate == 16'h0) else $error("wake failed");
	// Status shows the gates as they stood when the read was taken
	chk_status_read: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == 8'h08 |=> s_axi_rdata == {23'h0, $past(domainGate)}
		&& s_axi_rresp == 2'h0) else $error("status read wrong");
	chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == 8'h40 |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
		else $error("unmapped read answered");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read answer late");
	chk_write_done: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid) else $error("write response repeated");
	cover property (idleExec ##1 domainGate[4]);
	cover property (periphGate != 16'h0);
	cover property (irq);
endmodule

bind idle_domain_control_status idle_domain_properties chkU (.*);

`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the idle domain controller.
// Assumes the controller and its properties file are compiled first.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready = 1'b0;
	logic        idleExec = 1'b0;
	logic        wakeReq = 1'b0;
	logic [8:0]  domainGate;
	logic [15:0] periphGate;
	logic        irq;
	int          nFail = 0;
	int          comparisons = 0;

	idle_domain_control_status dut_u (.*);

	// --------------------------------------------------
	// Clock and shared tasks
	// --------------------------------------------------
	always #10 ref_clk = ~ref_clk;

	task automatic giveVerdict;
		$display("comparisons %0d mismatches %0d", comparisons, nFail);
		if (nFail == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			nFail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// A bus wait that runs out ends the run at once
	task automatic guard(input int n);
		if (n >= 40) begin
			nFail++;
			$display("[FAIL] %0t bus timeout", $time);
			giveVerdict();
		end
	endtask

	// Both write halves offered together; bready held until the answer
	task automatic wr(input logic [7:0] a, input logic [15:0] d,
			input logic [1:0] er);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 40);
		s_axi_bready <= 1'b0;
		guard(n);
		check({30'h0, s_axi_bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
			input logic [1:0] er);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 40);
		s_axi_rready <= 1'b0;
		guard(n);
		check(s_axi_rdata, ed);
		check({30'h0, s_axi_rresp}, {30'h0, er});
	endtask

	// One-cycle idle (wk low) or wake (wk high) pulse; the extra edge
	// lets the gates settle so a direct look after the call is valid
	task automatic pulse(input logic wk);
		@(posedge ref_clk);
		if (wk) wakeReq <= 1'b1;
		else idleExec <= 1'b1;
		@(posedge ref_clk);
		wakeReq <= 1'b0;
		idleExec <= 1'b0;
		@(posedge ref_clk);
	endtask

	// --------------------------------------------------
	// Scenarios
	// --------------------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		rd(8'h04, 32'h0, 2'h0);
		rd(8'h08, 32'h0, 2'h0);
		wr(8'h08, 16'h01ff, 2'h0);
		rd(8'h08, 32'h0, 2'h0);
		// Each domain alone except 3 and 4; the others must stay running
		for (int i = 0; i < 9; i++) begin
			if (i != 3 && i != 4) begin
				wr(8'h04, 16'h1 << i, 2'h0);
				pulse(1'b0);
				rd(8'h08, 32'h1 << i, 2'h0);
				check({23'h0, domainGate}, 32'h1 << i);
				pulse(1'b1);
			end
		end
		wr(8'h0c, 16'hea5a, 2'h0);
		rd(8'h0c, 32'h2a5a, 2'h0);
		wr(8'h04, 16'h0008, 2'h0);
		pulse(1'b0);
		rd(8'h08, 32'h0008, 2'h0);
		check({16'h0, periphGate}, 32'h2a5a);
		wr(8'h04, 16'h0000, 2'h0);
		pulse(1'b0);
		check({16'h0, periphGate}, 32'h0);
		rd(8'h08, 32'h0, 2'h0);
		// Clock generator without the other domains is refused
		wr(8'h18, 16'h0001, 2'h0);
		rd(8'h18, 32'h1, 2'h0);
		wr(8'h04, 16'h0010, 2'h0);
		pulse(1'b0);
		rd(8'h08, 32'h0, 2'h0);
		check({31'h0, irq}, 32'h1);
		wr(8'h18, 16'h0000, 2'h0);
		check({31'h0, irq}, 32'h0);
		wr(8'h18, 16'h0001, 2'h0);
		check({31'h0, irq}, 32'h1);
		wr(8'h14, 16'h0001, 2'h0);
		check({31'h0, irq}, 32'h0);
		rd(8'h10, 32'h6, 2'h0);
		wr(8'h04, 16'h03f7, 2'h0);
		pulse(1'b0);
		rd(8'h08, 32'h01f7, 2'h0);
		check({31'h0, irq}, 32'h0);
		check({23'h0, domainGate}, 32'h1f7);
		// Reset in mid-run while gated; every domain must come back
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		rd(8'h08, 32'h0, 2'h0);
		rd(8'h04, 32'h0, 2'h0);
		check({23'h0, domainGate}, 32'h0);
		pulse(1'b1);
		rd(8'h08, 32'h0, 2'h0);
		rd(8'h40, 32'h0, 2'h3);
		wr(8'h41, 16'h0001, 2'h3);
		wr(8'h05, 16'h0001, 2'h3);
		rd(8'h04, 32'h0, 2'h0);
		giveVerdict();
	end
endmodule

`default_nettype wire
